// [src/swt_top.sv]
// self wake-up timer: apb registers, prescaler, reload counter, interrupt
//
// Functional notes
// RL1 - keeps counting in idle and power-down
// RL2 - sole clock is 10 kHz oscillator
// RL3 - system clock at least twice timer clock
// RL4 - running timer keeps its oscillator on
// RL5 - software enables oscillator and awaits stability
// RL6 - eight-bit auto-reload up-counter at prescaled rate
// RL7 - prescale select divides by 1 to 2048
// RL8 - run bit one counts, zero halts
// RL9 - rollover from ff sets flag, reloads
// RL10 - flag with both enables requests interrupt; here irq follows sts, set with flag but cleared apart
// RL11 - only software clears the overflow flag
// RL12 - reload written only while halted; here a write while running lands as is
// RL13 - no reload ff with divide by one
// RL14 - control resets zero, flag/run/prescale layout
// RL15 - reload register read-write, resets to zero
// RL16 - start loads reload, clears prescaler
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module swt_top #(
	parameter int unsigned OSC_DIV = swt_pkg::OSC_DIV_CYC
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_n_in,
	input  wire swt_pkg::swt_apb_req_s apb_in,
	output swt_pkg::swt_apb_rsp_s      apb_out,
	output logic                       irq_out,
	output logic                       osc_active_out
);
	import swt_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]           reload;
		logic                 flag;
		logic                 run;
		logic [CTRL_PS_W-1:0] ps_sel;
		logic [7:0]           count;
		logic [PSC_W-1:0]     psc;
		logic                 sts;
		logic                 msk;
		logic                 gie;
		logic                 osc_en;
		logic                 osc_act;
		logic                 irq;
		logic                 pready;
		logic                 pslverr;
		logic [31:0]          prdata;
	} swt_state_s;

	swt_state_s st_q;
	swt_state_s st_d;

	logic       tick;
	logic       ovf_evt;
	logic       psc_end;
	logic       acc;
	logic       wr_go;
	logic       wr_ctrl;
	logic       mapped;
	logic [7:0] wbyte;
	logic [7:0] ctrl_rd;

	// ----------------------------------------------------------------
	// slow oscillator
	// ----------------------------------------------------------------
	// the tick source ignores every power mode, so the count goes on
	// through idle and power-down
	swt_osc_tick #(
		.DIV (OSC_DIV)
	) u_osc (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.enable_in (st_q.osc_act), // RL1
		.tick_out  (tick)
	);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign acc     = apb_in.psel && apb_in.penable;
	assign wr_go   = acc && st_q.pready && apb_in.pwrite &&
	                 apb_in.pstrb[0] && !st_q.pslverr;
	assign wr_ctrl = wr_go && swt_hit(apb_in.paddr, IDX_CTRL);
	assign wbyte   = apb_in.pwdata[7:0];

	assign mapped = swt_hit(apb_in.paddr, IDX_RELOAD)  ||
	                swt_hit(apb_in.paddr, IDX_CTRL)    ||
	                swt_hit(apb_in.paddr, IDX_IRQ_STS) ||
	                swt_hit(apb_in.paddr, IDX_IRQ_MSK) ||
	                swt_hit(apb_in.paddr, IDX_GIE)     ||
	                swt_hit(apb_in.paddr, IDX_OSC)     ||
	                swt_hit(apb_in.paddr, IDX_COUNT);

	// reserved bits 7..5 read as zero
	assign ctrl_rd = {3'h0, st_q.flag, st_q.run, st_q.ps_sel}; // RL14

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	assign psc_end = (st_q.psc == swt_ps_last(st_q.ps_sel)); // RL7
	assign ovf_evt = st_q.run && tick && psc_end &&
	                 (st_q.count == COUNT_MAX); // RL9

	always_comb begin
		st_d         = st_q;
		st_d.pready  = 1'b0;
		st_d.pslverr = 1'b0;

		// counting only while running; halted holds everything
		if (st_q.run && tick) begin // RL8
			if (psc_end) begin
				st_d.psc = '0;
				if (st_q.count == COUNT_MAX) begin
					st_d.count = st_q.reload; // RL9
				end else begin
					st_d.count = st_q.count + 8'h01; // RL6
				end
			end else begin
				st_d.psc = st_q.psc + 11'h001; // RL7
			end
		end

		// ------------------------------------------------------------
		// apb: read data in first access cycle, write on the
		// completing edge
		// ------------------------------------------------------------
		if (acc && !st_q.pready) begin
			st_d.pready  = 1'b1;
			st_d.pslverr = !mapped;
			st_d.prdata  = 32'h0000_0000;
			if (swt_hit(apb_in.paddr, IDX_RELOAD)) begin
				st_d.prdata = {24'h0, st_q.reload}; // RL15
			end
			if (swt_hit(apb_in.paddr, IDX_CTRL)) begin
				st_d.prdata = {24'h0, ctrl_rd}; // RL14
			end
			if (swt_hit(apb_in.paddr, IDX_IRQ_STS)) begin
				st_d.prdata = {31'h0, st_q.sts};
			end
			if (swt_hit(apb_in.paddr, IDX_IRQ_MSK)) begin
				st_d.prdata = {31'h0, st_q.msk};
			end
			if (swt_hit(apb_in.paddr, IDX_GIE)) begin
				st_d.prdata = {31'h0, st_q.gie};
			end
			if (swt_hit(apb_in.paddr, IDX_OSC)) begin
				st_d.prdata = {30'h0, st_q.osc_act, st_q.osc_en};
			end
			if (swt_hit(apb_in.paddr, IDX_COUNT)) begin
				st_d.prdata = {24'h0, st_q.count};
			end
		end

		if (wr_go && swt_hit(apb_in.paddr, IDX_RELOAD)) begin
			// a write while running lands as is; software must halt first
			st_d.reload = wbyte; // RL12
		end
		if (wr_ctrl) begin
			st_d.run    = wbyte[CTRL_RUN_BIT]; // RL8
			st_d.ps_sel = wbyte[CTRL_PS_LSB +: CTRL_PS_W]; // RL7
			st_d.flag   = wbyte[CTRL_FLAG_BIT]; // RL11
			if (wbyte[CTRL_RUN_BIT] && !st_q.run) begin
				// full first interval after a start
				st_d.count = st_q.reload; // RL16
				st_d.psc   = '0; // RL16
			end
		end
		if (wr_go && swt_hit(apb_in.paddr, IDX_IRQ_STS) && wbyte[0]) begin
			st_d.sts = 1'b0;
		end
		if (wr_go && swt_hit(apb_in.paddr, IDX_IRQ_MSK)) begin
			st_d.msk = wbyte[0];
		end
		if (wr_go && swt_hit(apb_in.paddr, IDX_GIE)) begin
			st_d.gie = wbyte[0];
		end
		if (wr_go && swt_hit(apb_in.paddr, IDX_OSC)) begin
			st_d.osc_en = wbyte[0]; // RL5
		end

		// hardware only ever sets; a same-cycle clear loses
		if (ovf_evt) begin
			st_d.flag = 1'b1; // RL9 RL11
			st_d.sts  = 1'b1;
		end

		// a running timer holds its oscillator on whatever software says
		st_d.osc_act = st_d.osc_en || st_d.run; // RL4
		st_d.irq     = st_d.sts && st_d.msk && st_d.gie; // RL10
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q        <= '0;
			st_q.reload <= RELOAD_RST; // RL15
			st_q.flag   <= CTRL_RST[CTRL_FLAG_BIT]; // RL14
			st_q.run    <= CTRL_RST[CTRL_RUN_BIT];
			st_q.ps_sel <= CTRL_RST[CTRL_PS_LSB +: CTRL_PS_W];
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign apb_out.pready  = st_q.pready;
	assign apb_out.pslverr = st_q.pslverr;
	assign apb_out.prdata  = st_q.prdata;
	assign irq_out         = st_q.irq;
	assign osc_active_out  = st_q.osc_act;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_rollover;
		st_q.run && tick && psc_end && st_q.count == COUNT_MAX &&
		!wr_ctrl;
	endsequence

	sequence s_start;
		wr_ctrl && wbyte[CTRL_RUN_BIT] && !st_q.run;
	endsequence

	sequence s_stop;
		wr_ctrl && !wbyte[CTRL_RUN_BIT];
	endsequence

	reload_on_ovf_a: assert property ( // RL9
		@(posedge clk_in) disable iff (!rst_n_in)
		s_rollover |=> st_q.count == $past(st_q.reload)
	) else $error("counter not reloaded on rollover");

	flag_on_ovf_a: assert property ( // RL9
		@(posedge clk_in) disable iff (!rst_n_in)
		ovf_evt |=> st_q.flag && st_q.sts
	) else $error("overflow did not set flag");

	flag_sticky_a: assert property ( // RL11
		@(posedge clk_in) disable iff (!rst_n_in)
		st_q.flag && !wr_ctrl |=> st_q.flag
	) else $error("overflow flag cleared by hardware");

	halt_hold_a: assert property ( // RL8
		@(posedge clk_in) disable iff (!rst_n_in)
		!st_q.run && !wr_ctrl |=> $stable(st_q.count) && $stable(st_q.psc)
	) else $error("halted counter moved");

	start_load_a: assert property ( // RL16
		@(posedge clk_in) disable iff (!rst_n_in)
		s_start |=> st_q.count == $past(st_q.reload) && st_q.psc == '0
	) else $error("start did not load reload value");

	prescale_gate_a: assert property ( // RL7
		@(posedge clk_in) disable iff (!rst_n_in)
		st_q.run && tick && !psc_end && !wr_ctrl |=>
			$stable(st_q.count) && st_q.psc == $past(st_q.psc) + 11'h001
	) else $error("counter stepped before prescaler end");

	irq_raise_a: assert property ( // RL10
		@(posedge clk_in) disable iff (!rst_n_in)
		ovf_evt && st_q.msk && st_q.gie && !wr_go |=> irq_out
	) else $error("enabled overflow raised no interrupt");

	osc_kept_a: assert property ( // RL4
		@(posedge clk_in) disable iff (!rst_n_in)
		st_q.run |-> osc_active_out
	) else $error("running timer lost its oscillator");

	apb_answer_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		acc && !st_q.pready |=> apb_out.pready ##1 !apb_out.pready
	) else $error("apb answer not one cycle after access");

	count_step_a: assert property ( // RL6
		@(posedge clk_in) disable iff (!rst_n_in)
		st_q.run && tick && psc_end && st_q.count != COUNT_MAX &&
			!wr_ctrl |=> st_q.count == $past(st_q.count) + 8'h01
	) else $error("counter did not step by one");

	psc_wrap_a: assert property ( // RL7
		@(posedge clk_in) disable iff (!rst_n_in)
		st_q.run && tick && psc_end && !wr_ctrl |=> st_q.psc == '0
	) else $error("prescaler did not restart at its end");

	stop_halt_a: assert property ( // RL8
		@(posedge clk_in) disable iff (!rst_n_in)
		s_stop |=> !st_q.run ##1 $stable(st_q.count)
	) else $error("counter moved after a stop");

	flag_source_a: assert property ( // RL9
		@(posedge clk_in) disable iff (!rst_n_in)
		!st_q.flag && !ovf_evt && !wr_ctrl |=> !st_q.flag
	) else $error("overflow flag set without an overflow");

	sts_hold_a: assert property ( // RL10
		@(posedge clk_in) disable iff (!rst_n_in)
		st_q.sts && !(wr_go && swt_hit(apb_in.paddr, IDX_IRQ_STS) &&
			wbyte[0]) |=> st_q.sts
	) else $error("status bit cleared without a write of one");

	irq_quiet_a: assert property ( // RL10
		@(posedge clk_in) disable iff (!rst_n_in)
		!st_q.sts && !ovf_evt |=> !irq_out
	) else $error("interrupt without a pending status");

	irq_masked_a: assert property ( // RL10
		@(posedge clk_in) disable iff (!rst_n_in)
		!st_q.msk && !wr_go |=> !irq_out
	) else $error("masked overflow raised the interrupt");

	ctrl_read_a: assert property ( // RL14
		@(posedge clk_in) disable iff (!rst_n_in)
		acc && !st_q.pready && swt_hit(apb_in.paddr, IDX_CTRL) |=>
			apb_out.prdata == {24'h0, 3'h0, $past(st_q.flag),
			$past(st_q.run), $past(st_q.ps_sel)}
	) else $error("control read shows a wrong layout");

	reload_read_a: assert property ( // RL15
		@(posedge clk_in) disable iff (!rst_n_in)
		acc && !st_q.pready && swt_hit(apb_in.paddr, IDX_RELOAD) |=>
			apb_out.prdata == {24'h0, $past(st_q.reload)}
	) else $error("reload read does not match the register");

	osc_cfg_a: assert property ( // RL5
		@(posedge clk_in) disable iff (!rst_n_in)
		wr_ctrl |=> st_q.osc_en == $past(st_q.osc_en)
	) else $error("control write touched the oscillator enable");

	// ----------------------------------------------------------------
	// bus checks
	// ----------------------------------------------------------------
	slverr_map_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		acc && !st_q.pready |=> apb_out.pslverr == !$past(mapped)
	) else $error("error response does not match the map");

	prdata_hold_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!(acc && !st_q.pready) |=> $stable(apb_out.prdata)
	) else $error("read data changed outside an answer");

endmodule // swt_top

// [src/swt_pkg.sv]
// constants, register map and carrier types of the self wake-up timer
package swt_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ = 250_000_000;
	localparam int unsigned OSC_FREQ_HZ = 10_000;
	localparam int unsigned OSC_DIV_CYC = CLK_FREQ_HZ / OSC_FREQ_HZ;

	// ----------------------------------------------------------------
	// register map: printed offsets are word indices
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_RELOAD  = 8'h86;
	localparam logic [7:0] IDX_CTRL    = 8'h8f;
	localparam logic [7:0] IDX_IRQ_STS = 8'h90;
	localparam logic [7:0] IDX_IRQ_MSK = 8'h91;
	localparam logic [7:0] IDX_GIE     = 8'h92;
	localparam logic [7:0] IDX_OSC     = 8'h93;
	localparam logic [7:0] IDX_COUNT   = 8'h94;
	localparam int unsigned ADDR_W     = 12;

	// control register fields
	localparam int unsigned CTRL_FLAG_BIT = 4;
	localparam int unsigned CTRL_RUN_BIT  = 3;
	localparam int unsigned CTRL_PS_LSB   = 0;
	localparam int unsigned CTRL_PS_W     = 3;

	// reset values and counter top count
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] COUNT_MAX  = 8'hff;

	localparam int unsigned PSC_W = 11;

	// ----------------------------------------------------------------
	// apb carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
		logic [3:0]        pstrb;
	} swt_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} swt_apb_rsp_s;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// terminal count of the prescaler: division factor minus one
	function automatic logic [PSC_W-1:0] swt_ps_last(
		input logic [CTRL_PS_W-1:0] sel
	);
		unique case (sel)
			3'h0: swt_ps_last = 11'h000;
			3'h1: swt_ps_last = 11'h003;
			3'h2: swt_ps_last = 11'h00f;
			3'h3: swt_ps_last = 11'h03f;
			3'h4: swt_ps_last = 11'h0ff;
			3'h5: swt_ps_last = 11'h1ff;
			3'h6: swt_ps_last = 11'h3ff;
			3'h7: swt_ps_last = 11'h7ff;
		endcase
	endfunction

	// match of a byte address against a word index, with alignment and range checked
	function automatic logic swt_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0]        idx
	);
		swt_hit = (addr == {2'h0, idx, 2'h0});
	endfunction

endpackage

// [src/swt_osc_tick.sv]
// low-power oscillator model: one tick per slow-clock period
`timescale 1ns/1ps
module swt_osc_tick #(
	parameter int unsigned DIV = swt_pkg::OSC_DIV_CYC
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic enable_in,
	output logic      tick_out
);
	import swt_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} swt_osc_state_s;

	localparam logic [15:0] LAST = 16'(DIV - 1);

	swt_osc_state_s st_q;
	swt_osc_state_s st_d;

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	always_comb begin
		st_d      = st_q;
		st_d.tick = 1'b0;
		if (!enable_in) begin
			// a stopped oscillator restarts a full period later
			st_d.cnt = 16'h0000;
		end else if (st_q.cnt == LAST) begin
			st_d.cnt  = 16'h0000;
			st_d.tick = 1'b1; // RL2
		end else begin
			st_d.cnt = st_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tick_out = st_q.tick;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	tick_single_a: assert property ( // RL2
		@(posedge clk_in) disable iff (!rst_n_in)
		(tick_out && DIV > 1) |=> !tick_out
	) else $error("oscillator tick lasted more than one cycle");

	tick_stopped_a: assert property ( // RL2
		@(posedge clk_in) disable iff (!rst_n_in)
		!enable_in |=> !tick_out
	) else $error("tick while oscillator disabled");

endmodule // swt_osc_tick

// [verification/self_wakeup_timer_tb.sv]
// self-checking bench of the self wake-up timer, driven over apb
`timescale 1ns/1ps
module self_wakeup_timer_tb;
	import swt_pkg::*;

	// ----------------------------------------------------------------
	// setup
	// ----------------------------------------------------------------
	// short oscillator period keeps the longest prescale run brief
	localparam int unsigned DIV = 4;
	localparam logic [ADDR_W-1:0] A_RLD = {2'h0, IDX_RELOAD, 2'h0};
	localparam logic [ADDR_W-1:0] A_CTL = {2'h0, IDX_CTRL, 2'h0};
	localparam logic [ADDR_W-1:0] A_STS = {2'h0, IDX_IRQ_STS, 2'h0};
	localparam logic [ADDR_W-1:0] A_MSK = {2'h0, IDX_IRQ_MSK, 2'h0};
	localparam logic [ADDR_W-1:0] A_GIE = {2'h0, IDX_GIE, 2'h0};
	localparam logic [ADDR_W-1:0] A_CNT = {2'h0, IDX_COUNT, 2'h0};
	localparam logic [ADDR_W-1:0] A_OSC = {2'h0, IDX_OSC, 2'h0};

	logic         clk_in     = 1'b0;
	logic         rst_n_in   = 1'b0;
	swt_apb_req_s apb_req    = '0;
	swt_apb_rsp_s apb_rsp;
	logic         irq;
	logic         osc_act;
	int           n_mismatch = 0;
	int           n_compared = 0;
	int           cyc        = 0;
	logic [31:0]  cnt_a;

	always #2 clk_in = ~clk_in;

	swt_top #(.OSC_DIV(DIV)) i_dut (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.apb_in        (apb_req),
		.apb_out       (apb_rsp),
		.irq_out       (irq),
		.osc_active_out(osc_act)
	);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic give_verdict();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one transfer; the edge before setup keeps back-to-back calls apart
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
			input logic [7:0] d, output logic [31:0] q, output logic e);
		int w;
		w = 0;
		@(posedge clk_in);
		apb_req <= '{1'b1, 1'b0, wr, a, {24'h0, d}, 4'hf};
		@(posedge clk_in);
		apb_req.penable <= 1'b1;
		// no local limit: a hang is caught by the cycle ceiling
		do begin
			@(posedge clk_in);
			w++;
		end while (apb_rsp.pready !== 1'b1);
		q = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req <= '0;
		chk(w, 32'h2);
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 8'h00, q, e);
		chk(q, {24'h0, x});
	endtask

	// start at reload fe; irq must follow two counts of the prescaled tick
	task automatic run_ps(input logic [2:0] s);
		int f;
		int n;
		f = (s <= 3'h4) ? (1 << (2 * s)) : (1 << (s + 4));
		n = 0;
		wr(A_CTL, 8'h00);
		wr(A_STS, 8'h01);
		wr(A_CTL, {5'h01, s});
		while (irq !== 1'b1 && n < 2 * f * DIV + 40) begin
			@(posedge clk_in);
			n++;
		end
		n_compared++;
		if (n < 2 * f * DIV - DIV || n > 2 * f * DIV + DIV + 4) begin
			n_mismatch++;
			$display("[ERR] %0t sel %0d took %0d cycles", $time, s, n);
		end
		chk({31'h0, osc_act}, 32'h1);
		repeat (20) @(posedge clk_in);
		rdc(A_CTL, {5'h03, s});
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial begin
		logic [31:0] q;
		logic        e;
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		chk({30'h0, irq, osc_act}, 32'h0);
		wr(A_OSC, 8'h01);
		repeat (8) @(posedge clk_in);
		rdc(A_OSC, 8'h03);
		rdc(A_RLD, 8'h00);
		rdc(A_CTL, 8'h00);
		wr(A_RLD, 8'ha5);
		rdc(A_RLD, 8'ha5);
		wr(A_CTL, 8'he7);
		rdc(A_CTL, 8'h07);
		apb(1'b1, 12'hffc, 8'h5a, q, e);
		chk({31'h0, e}, 32'h1);
		apb(1'b0, 12'hffc, 8'h00, q, e);
		chk({e, q[30:0]}, 32'h80000000);
		// halted counter keeps its value
		wr(A_CTL, 8'h00);
		wr(A_RLD, 8'h10);
		wr(A_CTL, 8'h08);
		repeat (30) @(posedge clk_in);
		wr(A_CTL, 8'h00);
		apb(1'b0, A_CNT, 8'h00, cnt_a, e);
		chk({31'h0, cnt_a[7:0] > 8'h10}, 32'h1);
		repeat (40) @(posedge clk_in);
		rdc(A_CNT, cnt_a[7:0]);
		wr(A_CTL, 8'h0f);
		rdc(A_CNT, 8'h10);
		// prescale sweep with the interrupt enabled
		wr(A_CTL, 8'h00);
		wr(A_RLD, 8'hfe);
		wr(A_MSK, 8'h01);
		wr(A_GIE, 8'h01);
		for (int s = 0; s < 8; s++) begin
			run_ps(s[2:0]);
		end
		wr(A_OSC, 8'h00);
		rdc(A_OSC, 8'h02);
		wr(A_CTL, 8'h17);
		rdc(A_OSC, 8'h00);
		rdc(A_STS, 8'h01);
		wr(A_MSK, 8'h00);
		@(posedge clk_in);
		chk({31'h0, irq}, 32'h0);
		wr(A_MSK, 8'h01);
		@(posedge clk_in);
		chk({31'h0, irq}, 32'h1);
		wr(A_GIE, 8'h00);
		@(posedge clk_in);
		chk({31'h0, irq}, 32'h0);
		wr(A_GIE, 8'h01);
		wr(A_STS, 8'h01);
		@(posedge clk_in);
		chk({31'h0, irq}, 32'h0);
		rdc(A_CTL, 8'h17);
		wr(A_CTL, 8'h07);
		rdc(A_CTL, 8'h07);
		give_verdict();
	end

endmodule // self_wakeup_timer_tb
